/* bench/pmc_cpu_model.sv */
module pmc_cpu_model (
    input  logic i_ref_clk,
    output logic o_sleep,
    output logic o_wake,
    output logic o_watch_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_r = 3'h0;

    initial begin
        o_sleep = 1'b0;
        o_wake = 1'b0;
        o_watch_tick = 1'b0;
    end

    // the watch oscillator keeps running in every mode, so its ticks never pause
    always @(posedge i_ref_clk) begin
        div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
        o_watch_tick <= (div_r == 3'h4);
    end

    task automatic sleep_now;
        @(posedge i_ref_clk);
        o_sleep <= 1'b1;
        @(posedge i_ref_clk);
        o_sleep <= 1'b0;
    endtask

    task automatic wake_now;
        @(posedge i_ref_clk);
        o_wake <= 1'b1;
        @(posedge i_ref_clk);
        o_wake <= 1'b0;
    endtask
endmodule // pmc_cpu_model

/* bench/pmc_top_monitor.sv */
`include "pmc_regs.vh"

module pmc_top_monitor #(
    parameter [17:0] WAIT_128K = `PMC_WAIT_128K
) (
    input logic                   i_ref_clk,
    input logic                   i_rst_b,
    input logic                   i_psel,
    input logic                   i_penable,
    input logic                   i_pwrite,
    input logic [`PMC_ADDR_W-1:0] i_paddr,
    input logic [31:0]            i_pwdata,
    input logic [31:0]            o_prdata,
    input logic                   o_pready,
    input logic                   o_pslverr,
    input logic                   i_sleep,
    input logic                   i_wake,
    input logic                   i_watch_tick,
    input logic [2:0]             o_mode,
    input logic                   o_cpu_on_sub,
    input logic                   o_medium_tick,
    input logic                   o_sub_tick,
    input logic                   o_noise_tick,
    input logic                   o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [17:0] settle_r;

    // counts the settling cycles already spent, so the longest wait code bounds the stay
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            settle_r <= 18'h0;
        else
            settle_r <= (o_mode == 3'h7) ? settle_r + 18'h1 : 18'h0;
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_access;
        i_psel && i_penable && !$past(i_penable);
    endsequence
    sequence s_settle_end;
        (o_mode == 3'h7) ##1 (o_mode != 3'h7);
    endsequence

    a_ready_wait: assert property (s_access |=> o_pready)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    a_active_sleep: assert property (o_mode <= 3'h1 && i_sleep |=>
        o_mode != $past(o_mode) && o_mode != 3'h4 && o_mode != 3'h7)
        else $error("bad mode after sleep in active");
    a_sub_sleep: assert property (o_mode == 3'h2 && i_sleep |=>
        o_mode inside {3'h0, 3'h1, 3'h4, 3'h6})
        else $error("bad mode after sleep in subactive");
    a_low_hold: assert property (o_mode inside {[3'h3:3'h6]} && !i_wake |=>
        $stable(o_mode))
        else $error("low power mode left without wake");
    a_sub_level: assert property (o_cpu_on_sub == (o_mode == 3'h2 || o_mode == 3'h4))
        else $error("subclock flag disagrees with mode");
    a_noise_gap: assert property (o_noise_tick |=> !o_noise_tick [*3])
        else $error("noise ticks too close");
    a_medium_gap: assert property (o_medium_tick |=> !o_medium_tick [*8])
        else $error("medium ticks too close");
    a_settle_len: assert property (o_mode == 3'h7 |-> settle_r < WAIT_128K)
        else $error("settling wait too long");
    a_settle_exit: assert property (s_settle_end |-> o_mode <= 3'h1)
        else $error("settling did not end in active");
endmodule // pmc_top_monitor

bind pmc_top pmc_top_monitor #(.WAIT_128K(WAIT_128K)) pmc_top_monitor_i (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep), .i_wake(i_wake),
    .i_watch_tick(i_watch_tick), .o_mode(o_mode), .o_cpu_on_sub(o_cpu_on_sub),
    .o_medium_tick(o_medium_tick), .o_sub_tick(o_sub_tick), .o_noise_tick(o_noise_tick),
    .o_irq(o_irq));

/* bench/pmc_top_tb.sv */
`include "pmc_regs.vh"

module pmc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic        err;
    wire  [31:0] prdata;
    wire  [2:0]  mode;
    wire         pready, pslverr, sleep, wake, wtick, on_sub, med, sub, noise, irq;
    wire  [2:0]  ticks = {sub, noise, med};
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          waits [8] = '{8, 16, 20, 40, 60, 2, 8, 8};
    int          subp [4] = '{40, 20, 10, 10};
    // sc1, sc2, timer, mode after sleep, mode after wake
    logic [39:0] tbl [10] = '{40'h0000000300, 40'h8000010600, 40'h000c000101, 40'h0008000000,
        40'h8808010202, 40'h0000000402, 40'h8800010602, 40'h800c010101, 40'h8808010202,
        40'h8008010000};

    always #50 clk = ~clk;

    pmc_top #(.WAIT_32K(18'd20), .WAIT_64K(18'd40), .WAIT_128K(18'd60)) pmc_top_i (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sleep(sleep), .i_wake(wake),
        .i_watch_tick(wtick), .o_mode(mode), .o_cpu_on_sub(on_sub), .o_medium_tick(med),
        .o_sub_tick(sub), .o_noise_tick(noise), .o_irq(irq));
    pmc_cpu_model pmc_cpu_model_i (.i_ref_clk(clk), .o_sleep(sleep), .o_wake(wake),
        .o_watch_tick(wtick));

    task automatic stop_test;
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk("rdata", exp, rd);
        chk("pslverr", {31'h0, e}, {31'h0, err});
    endtask

    task automatic per(input int s, input int exp);
        int n;
        n = 0;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ticks[s] !== 1'b1 && n < 400);
        end
        chk("period", exp, n);
    endtask

    task automatic step(input logic [39:0] r);
        int n;
        logic [31:0] exp_m;
        n = 0;
        exp_m = {29'h0, r[10:8]};
        wr(`PMC_OFS_SYSCTL1, r[39:32]);
        wr(`PMC_OFS_SYSCTL2, r[31:24]);
        wr(`PMC_OFS_TIMER_CTL, r[23:16]);
        pmc_cpu_model_i.sleep_now();
        @(posedge clk);
        if (r[10:8] > 3'h2)
            chk("mode", exp_m, {29'h0, mode});
        else
            chk("mode", exp_m, {29'h0, mode});
        chk("on_sub", {31'h0, (r[10:8] == 3'h2) || (r[10:8] == 3'h4)}, {31'h0, on_sub});
        rdc(`PMC_OFS_IRQ_STATUS, {31'h0, r[10:8] < 3'h3}, 1'b0);
        chk("irq", {31'h0, r[10:8] < 3'h3}, {31'h0, irq});
        if (r[10:8] > 3'h2) begin
            pmc_cpu_model_i.wake_now();
            while (mode > 3'h2 && n < 200) begin
                @(posedge clk);
                n++;
            end
            chk("return", {29'h0, r[2:0]}, {29'h0, mode});
            chk("irq", 32'h0, {31'h0, irq});
            // leaving standby or watch raises the wake-done flag, sleep and subsleep do not
            rdc(`PMC_OFS_IRQ_STATUS, {30'h0, r[10:8] > 3'h4, 1'b0}, 1'b0);
        end
        wr(`PMC_OFS_IRQ_CLEAR, 8'h00);
        rdc(`PMC_OFS_IRQ_STATUS, 32'h0, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rdc(`PMC_OFS_SYSCTL1, 32'h07, 1'b0);
        rdc(`PMC_OFS_SYSCTL2, 32'hf0, 1'b0);
        rdc(`PMC_OFS_IRQ_ENABLE, 32'h0, 1'b0);
        rdc(12'h200, 32'h0, 1'b1);
        per(1, 4);
        wr(`PMC_OFS_SYSCTL2, 8'h00);
        per(1, 16);
        wr(`PMC_OFS_IRQ_ENABLE, 8'h01);
        foreach (tbl[i]) step(tbl[i]);
        wr(`PMC_OFS_SYSCTL2, 8'h00);
        wr(`PMC_OFS_TIMER_CTL, 8'h00);
        for (int c = 0; c < 8; c++) begin
            int n;
            wr(`PMC_OFS_SYSCTL1, {1'b1, c[2:0], 4'h0});
            pmc_cpu_model_i.sleep_now();
            @(posedge clk);
            chk("mode", 32'h5, {29'h0, mode});
            pmc_cpu_model_i.wake_now();
            n = 0;
            while (mode !== 3'h7 && n < 20) begin
                @(posedge clk);
                n++;
            end
            n = 0;
            while (mode === 3'h7) begin
                n++;
                @(posedge clk);
            end
            chk("settle", waits[c], n);
            chk("mode", 32'h0, {29'h0, mode});
            wr(`PMC_OFS_IRQ_CLEAR, 8'h00);
        end
        wr(`PMC_OFS_SYSCTL1, 8'h00);
        rdc(`PMC_OFS_SYSCTL1, 32'h04, 1'b0);
        for (int c = 0; c < 4; c++) begin
            wr(`PMC_OFS_SYSCTL1, {6'h0, c[1:0]});
            per(0, 16 << c);
            wr(`PMC_OFS_SYSCTL2, {6'h0, c[1:0]});
            per(2, subp[c]);
        end
        stop_test();
    end

    // the whole sequence needs only a few thousand cycles
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
endmodule // pmc_top_tb

/* rtl/pmc_regs.vh */
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
// Summary of operation
// [RULE1] With standby_on_sleep at 0, a sleep instruction moves active mode to sleep and subactive mode to subsleep.
// [RULE2] With standby_on_sleep at 1, a sleep instruction moves active mode to standby or watch and subactive mode to watch.
// [RULE3] With direct_transfer_on clear, a sleep instruction only gives the ordinary low-power entries.
// [RULE4] Direct transfer from high-speed to medium-speed active needs standby_on_sleep 0, medium_speed_on 1, subclock_select 0.
// [RULE5] Direct transfer from medium-speed to high-speed active needs standby_on_sleep, medium_speed_on and subclock_select all 0.
// [RULE6] Direct transfer from either active mode to subactive needs standby_on_sleep 1, timer_a_clock_bit 1, subclock_select 1.
// [RULE7] Direct transfer from subactive to high-speed active needs standby_on_sleep 1, timer_a_clock_bit 1, subclock_select 0, medium_speed_on 0.
// [RULE8] Direct transfer from subactive to medium-speed active needs standby_on_sleep 1, timer_a_clock_bit 1, subclock_select 0, medium_speed_on 1.
// [RULE9] noise_sample_select 0 samples noise at the oscillator clock over 16, and 1 at the oscillator clock over 4.
// [RULE10] The wake-wait field sets the settling wait on leaving standby: 8, 16, 32768, 65536, 131072 or 2 states.
// [RULE11] Each direct transition sets direct_transition_flag, which software clears by writing 0.
// [RULE12] medium_div picks the medium-speed clock as the oscillator clock over 16, 32, 64 or 128.
// [RULE13] sub_div picks the subactive clock as the watch clock over 8, 4, or 2 when its upper bit is 1.

`define PMC_ADDR_W          12
`define PMC_OFS_SYSCTL1     12'h0f0
`define PMC_OFS_SYSCTL2     12'h0f4
`define PMC_OFS_TIMER_CTL   12'h0f8
`define PMC_OFS_IRQ_STATUS  12'h0fc
`define PMC_OFS_IRQ_CLEAR   12'h100
`define PMC_OFS_IRQ_ENABLE  12'h104
`define PMC_OFS_MODE_STAT   12'h108

`define PMC_SYSCTL1_RST     8'h07
`define PMC_SYSCTL2_RST     8'hf0
`define PMC_SC1_STANDBY_BIT 7
`define PMC_SC1_WAIT_HI     6
`define PMC_SC1_WAIT_LO     4
`define PMC_SC1_SUBCLK_BIT  3
`define PMC_SC1_ONES        8'h04
`define PMC_SC2_NOISE_BIT   4
`define PMC_SC2_DIRECT_BIT  3
`define PMC_SC2_MEDIUM_BIT  2
`define PMC_SC2_ONES        8'he0

`define PMC_IRQ_N           2
`define PMC_IRQ_DIRECT      0
`define PMC_IRQ_WOKE        1

`define PMC_WAIT_8          18'd8
`define PMC_WAIT_16         18'd16
`define PMC_WAIT_32K        18'd32768
`define PMC_WAIT_64K        18'd65536
`define PMC_WAIT_128K       18'd131072
`define PMC_WAIT_2          18'd2
`endif

/* rtl/pmc_top.v */
`include "pmc_regs.vh"

module pmc_top #(
    parameter [17:0] WAIT_32K  = `PMC_WAIT_32K,
    parameter [17:0] WAIT_64K  = `PMC_WAIT_64K,
    parameter [17:0] WAIT_128K = `PMC_WAIT_128K
) (
    input  wire                   i_ref_clk,
    input  wire                   i_rst_b,
    input  wire                   i_psel,
    input  wire                   i_penable,
    input  wire                   i_pwrite,
    input  wire [`PMC_ADDR_W-1:0] i_paddr,
    input  wire [31:0]            i_pwdata,
    output reg  [31:0]            o_prdata,
    output reg                    o_pready,
    output reg                    o_pslverr,
    input  wire                   i_sleep,
    input  wire                   i_wake,
    input  wire                   i_watch_tick,
    output reg  [2:0]             o_mode,
    output reg                    o_cpu_on_sub,
    output reg                    o_medium_tick,
    output reg                    o_sub_tick,
    output reg                    o_noise_tick,
    output reg                    o_irq
);

    localparam [2:0] M_HIGH    = 3'h0;
    localparam [2:0] M_MEDIUM  = 3'h1;
    localparam [2:0] M_SUB     = 3'h2;
    localparam [2:0] M_SLEEP   = 3'h3;
    localparam [2:0] M_SUBSLP  = 3'h4;
    localparam [2:0] M_STANDBY = 3'h5;
    localparam [2:0] M_WATCH   = 3'h6;
    localparam [2:0] M_SETTLE  = 3'h7;

    reg  [7:0]  sysctl1_r;
    reg  [7:0]  sysctl2_r;
    reg         timer_a_clock_bit_r;
    reg  [`PMC_IRQ_N-1:0] irq_stat_r;
    reg  [`PMC_IRQ_N-1:0] irq_en_r;
    reg  [2:0]  mode_nxt;
    reg  [2:0]  ret_mode_r;
    reg  [2:0]  ret_mode_nxt;
    reg  [17:0] wait_cnt_r;
    reg  [17:0] wait_cnt_nxt;
    reg         direct_nxt;
    reg         woke_nxt;
    reg  [6:0]  prescale_r;
    reg  [2:0]  sub_cnt_r;
    reg  [31:0] rdata_nxt;

    wire standby_on_sleep    = sysctl1_r[`PMC_SC1_STANDBY_BIT];
    wire [2:0] wake_wait_sel = sysctl1_r[`PMC_SC1_WAIT_HI:`PMC_SC1_WAIT_LO];
    wire subclock_select     = sysctl1_r[`PMC_SC1_SUBCLK_BIT];
    wire [1:0] medium_div    = sysctl1_r[1:0];
    wire noise_sample_select = sysctl2_r[`PMC_SC2_NOISE_BIT];
    wire direct_transfer_on  = sysctl2_r[`PMC_SC2_DIRECT_BIT];
    wire medium_speed_on     = sysctl2_r[`PMC_SC2_MEDIUM_BIT];
    wire [1:0] sub_div       = sysctl2_r[1:0];

    // register index; 3'h7 flags an unmapped address
    function [2:0] reg_index;
        input [`PMC_ADDR_W-1:0] addr;
        begin
            case (addr)
                `PMC_OFS_SYSCTL1:    reg_index = 3'h0;
                `PMC_OFS_SYSCTL2:    reg_index = 3'h1;
                `PMC_OFS_TIMER_CTL:  reg_index = 3'h2;
                `PMC_OFS_IRQ_STATUS: reg_index = 3'h3;
                `PMC_OFS_IRQ_CLEAR:  reg_index = 3'h4;
                `PMC_OFS_IRQ_ENABLE: reg_index = 3'h5;
                `PMC_OFS_MODE_STAT:  reg_index = 3'h6;
                default:             reg_index = 3'h7;
            endcase
        end
    endfunction

    function [17:0] wait_states;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    wait_states = `PMC_WAIT_8;
                3'h1:    wait_states = `PMC_WAIT_16;
                3'h2:    wait_states = WAIT_32K;
                3'h3:    wait_states = WAIT_64K;
                3'h4:    wait_states = WAIT_128K;
                3'h5:    wait_states = `PMC_WAIT_2;
                default: wait_states = `PMC_WAIT_8;
            endcase
        end
    endfunction

    wire [2:0] rd_idx  = reg_index(i_paddr);
    wire       acc_end = i_psel & i_penable & o_pready;
    wire       wr_en   = acc_end & i_pwrite;
    wire       wr_sc1  = wr_en & (reg_index(i_paddr) == 3'h0);
    wire       wr_sc2  = wr_en & (reg_index(i_paddr) == 3'h1);
    wire       wr_tmr  = wr_en & (reg_index(i_paddr) == 3'h2);
    wire       wr_clr  = wr_en & (reg_index(i_paddr) == 3'h4);
    wire       wr_ien  = wr_en & (reg_index(i_paddr) == 3'h5);

    // one wait state per access, so o_pready can come from a flop
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end else begin
            o_pready  <= i_psel & i_penable & ~o_pready;
            o_pslverr <= i_psel & i_penable & ~o_pready & (rd_idx == 3'h7);
            o_prdata  <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rdata_nxt : 32'h0;
        end
    end

    always @* begin
        case (rd_idx)
            3'h0:    rdata_nxt = {24'h0, sysctl1_r};
            3'h1:    rdata_nxt = {24'h0, sysctl2_r};
            3'h2:    rdata_nxt = {31'h0, timer_a_clock_bit_r};
            3'h3:    rdata_nxt = {30'h0, irq_stat_r};
            3'h5:    rdata_nxt = {30'h0, irq_en_r};
            3'h6:    rdata_nxt = {6'h0, wait_cnt_r, 1'b0, ret_mode_r, 1'b0, o_mode};
            default: rdata_nxt = 32'h0;
        endcase
    end

    // reserved bits of both system control registers are held at one whatever is written
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sysctl1_r           <= `PMC_SYSCTL1_RST;
            sysctl2_r           <= `PMC_SYSCTL2_RST;
            timer_a_clock_bit_r <= 1'b0;
            irq_en_r            <= {`PMC_IRQ_N{1'b0}};
        end else begin
            if (wr_sc1)
                sysctl1_r <= i_pwdata[7:0] | `PMC_SC1_ONES;
            if (wr_sc2)
                sysctl2_r <= i_pwdata[7:0] | `PMC_SC2_ONES;
            if (wr_tmr)
                timer_a_clock_bit_r <= i_pwdata[0];
            if (wr_ien)
                irq_en_r <= i_pwdata[`PMC_IRQ_N-1:0];
        end
    end

    // mode selection on a sleep instruction and return on a wake event
    always @* begin
        mode_nxt     = o_mode;
        ret_mode_nxt = ret_mode_r;
        wait_cnt_nxt = wait_cnt_r;
        direct_nxt   = 1'b0;
        woke_nxt     = 1'b0;
        case (o_mode)
            M_HIGH, M_MEDIUM: begin
                if (i_sleep) begin
                    ret_mode_nxt = o_mode;
                    if (direct_transfer_on && o_mode == M_HIGH && !standby_on_sleep
                        && medium_speed_on && !subclock_select) begin
                        mode_nxt   = M_MEDIUM; // [RULE4]
                        direct_nxt = 1'b1;
                    end else if (direct_transfer_on && o_mode == M_MEDIUM
                        && !standby_on_sleep && !medium_speed_on && !subclock_select) begin
                        mode_nxt   = M_HIGH; // [RULE5]
                        direct_nxt = 1'b1;
                    end else if (direct_transfer_on && standby_on_sleep
                        && timer_a_clock_bit_r && subclock_select) begin
                        mode_nxt   = M_SUB; // [RULE6]
                        direct_nxt = 1'b1;
                    end else if (!standby_on_sleep) begin
                        mode_nxt = M_SLEEP; // [RULE1] [RULE3]
                    end else if (timer_a_clock_bit_r) begin
                        mode_nxt = M_WATCH; // [RULE2] [RULE3]
                    end else begin
                        mode_nxt = M_STANDBY; // [RULE2] [RULE3]
                    end
                end
            end
            M_SUB: begin
                if (i_sleep) begin
                    ret_mode_nxt = M_SUB;
                    if (direct_transfer_on && standby_on_sleep && timer_a_clock_bit_r
                        && !subclock_select) begin
                        // [RULE7] [RULE8]
                        mode_nxt   = medium_speed_on ? M_MEDIUM : M_HIGH;
                        direct_nxt = 1'b1;
                    end else if (standby_on_sleep) begin
                        mode_nxt = M_WATCH; // [RULE2] [RULE3]
                    end else begin
                        mode_nxt = M_SUBSLP; // [RULE1] [RULE3]
                    end
                end
            end
            M_SLEEP: begin
                if (i_wake)
                    mode_nxt = ret_mode_r;
            end
            M_SUBSLP: begin
                if (i_wake)
                    mode_nxt = M_SUB;
            end
            M_STANDBY, M_WATCH: begin
                // watch with the subclock selected needs no oscillator restart
                if (i_wake && o_mode == M_WATCH && subclock_select) begin
                    mode_nxt = M_SUB;
                    woke_nxt = 1'b1;
                end else if (i_wake) begin
                    mode_nxt     = M_SETTLE;
                    wait_cnt_nxt = wait_states(wake_wait_sel); // [RULE10]
                end
            end
            M_SETTLE: begin
                if (wait_cnt_r <= 18'd1) begin
                    wait_cnt_nxt = 18'd0;
                    mode_nxt     = medium_speed_on ? M_MEDIUM : M_HIGH;
                    woke_nxt     = 1'b1;
                end else begin
                    wait_cnt_nxt = wait_cnt_r - 18'd1;
                end
            end
            default: mode_nxt = M_HIGH;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mode       <= M_HIGH;
            ret_mode_r   <= M_HIGH;
            wait_cnt_r   <= 18'd0;
            o_cpu_on_sub <= 1'b0;
        end else begin
            o_mode       <= mode_nxt;
            ret_mode_r   <= ret_mode_nxt;
            wait_cnt_r   <= wait_cnt_nxt;
            o_cpu_on_sub <= (mode_nxt == M_SUB) | (mode_nxt == M_SUBSLP);
        end
    end

    // sticky event flags; a set in the same cycle as a clear wins
    wire [`PMC_IRQ_N-1:0] irq_set = {woke_nxt, direct_nxt};
    genvar g;
    generate
        for (g = 0; g < `PMC_IRQ_N; g = g + 1) begin : g_irq
            always @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b)
                    irq_stat_r[g] <= 1'b0;
                else if (irq_set[g])
                    irq_stat_r[g] <= 1'b1; // [RULE11]
                else if (wr_clr && !i_pwdata[g])
                    irq_stat_r[g] <= 1'b0; // [RULE11]
            end
        end
    endgenerate

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_stat_r & irq_en_r);
    end

    // free-running prescaler on the oscillator clock shared by both dividers
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prescale_r    <= 7'h0;
            o_medium_tick <= 1'b0;
            o_noise_tick  <= 1'b0;
        end else begin
            prescale_r <= prescale_r + 7'h1;
            case (medium_div)
                2'h0:    o_medium_tick <= (prescale_r[3:0] == 4'hf); // [RULE12]
                2'h1:    o_medium_tick <= (prescale_r[4:0] == 5'h1f); // [RULE12]
                2'h2:    o_medium_tick <= (prescale_r[5:0] == 6'h3f); // [RULE12]
                default: o_medium_tick <= (prescale_r == 7'h7f); // [RULE12]
            endcase
            o_noise_tick <= noise_sample_select ? (prescale_r[1:0] == 2'h3)
                                                : (prescale_r[3:0] == 4'hf); // [RULE9]
        end
    end

    // subclock divider advances only on watch clock ticks
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sub_cnt_r  <= 3'h0;
            o_sub_tick <= 1'b0;
        end else begin
            if (i_watch_tick)
                sub_cnt_r <= sub_cnt_r + 3'h1;
            if (sub_div[1])
                o_sub_tick <= i_watch_tick & sub_cnt_r[0]; // [RULE13]
            else if (sub_div[0])
                o_sub_tick <= i_watch_tick & (sub_cnt_r[1:0] == 2'h3); // [RULE13]
            else
                o_sub_tick <= i_watch_tick & (sub_cnt_r == 3'h7); // [RULE13]
        end
    end

endmodule // pmc_top
